/* shared/shcp_pkg.sv */
package shcp_pkg;

	// envelope population: pitch envelopes first, then harmonic envelopes
	localparam int NUM_VOICES = 8;
	localparam int NUM_HARM = 64;
	localparam int NUM_ENV = NUM_VOICES + NUM_HARM;
	localparam int ENV_AW = 7;
	localparam logic [6:0] HARM_BASE = 7'h08;
	localparam logic [6:0] ENV_LAST = 7'h47;
	localparam int NUM_PAIRS = 32;

	// envelope entry layout {current, target, slope}
	localparam int SLOPE_W = 8;
	localparam int TGT_W = 13;
	localparam int CUR_W = 18;
	localparam int FRAC_W = 5;
	localparam int SLOPE_LSB = 0;
	localparam int TGT_LSB = 8;
	localparam int CUR_LSB = 21;
	localparam int ENTRY_W = 39;

	// slope byte fields
	localparam int SLOPE_SIGN_BIT = 7;
	localparam int RATE_EXP_HI_BIT = 6;
	localparam int RATE_EXP_LO_BIT = 5;
	localparam int MANT_W = 5;
	localparam int MANT_MAX = 31;

	// update divisors, expressed as masks on the subsample counter
	localparam int SUB_W = 7;
	localparam logic [6:0] RATE_MASK_EVERY2 = 7'h01;
	localparam logic [6:0] RATE_MASK_EVERY8 = 7'h07;
	localparam logic [6:0] RATE_MASK_EVERY32 = 7'h1f;
	localparam logic [6:0] RATE_MASK_EVERY128 = 7'h7f;

	// register select codes
	localparam logic [1:0] SEL_CMD = 2'h0;
	localparam logic [1:0] SEL_A = 2'h1;
	localparam logic [1:0] SEL_B = 2'h2;
	localparam logic [1:0] SEL_C = 2'h3;

	// opcodes
	localparam logic [4:0] OP5_WR_PITCH = 5'h01;
	localparam logic [4:0] OP5_WR_VTYPE = 5'h02;
	localparam logic [4:0] OP5_RD_PITCH = 5'h03;
	localparam logic [3:0] OP4_WR_OPT = 4'h2;
	localparam logic [3:0] OP4_WR_CTL = 4'h3;
	localparam logic [1:0] OP2_WR_HARM = 2'h1;
	localparam logic [1:0] OP2_WR_PAIR = 2'h2;
	localparam logic [1:0] OP2_RD_HARM = 2'h3;

	// option and control bits
	localparam logic [3:0] OPTIONS_RST = 4'h0;
	localparam logic [1:0] CONTROL_RST = 2'h0;
	localparam int OPT_ALE_BIT = 0;
	localparam int OPT_INT_BIT = 1;
	localparam int CTL_RUN_BIT = 0;
	localparam int CTL_NOISE_INIT_BIT = 1;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC,
		ST_SWEEP
	} shcp_state_t;

endpackage

/* hdl/shcp_env_ram.sv */
`timescale 1ns/100ps
module shcp_env_ram #(
	parameter int WIDTH = 39,
	parameter int DEPTH = 72,
	parameter int AW = 7
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] mem [DEPTH];

	// contents are not cleared; software loads every envelope after reset
	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule

/* hdl/shcp_command_port.sv */
`timescale 1ns/100ps
// Functional notes
// - each envelope ramps toward target by slope, then holds with slope cleared
// - slope byte: sign bit 7, rate exponent bits 6-5, mantissa bits 4-0
// - sign and mantissa form a two's complement step added to current
// - exponent 11,10,01,00 update every 2nd,8th,32nd,128th sample
// - pitch step is 1/2048 semitone, at most 31 steps up or 32 down per update
// - amplitude step is 1/128 dB, at most 31 steps up or 32 down per update
// - amplitude target is 8 bits in quarter dB, all ones 63.75 dB
// - pitch target is 13 bits in 1/64 semitone units
// - command byte captured on trailing edge of write with command selected
// - opcodes 00001/00010/00011 plus voice: pitch breakpoint, voice type, read pitch
// - opcode 0010 loads four option bits, 0011 loads two control bits
// - opcode 01 writes harmonic breakpoint, 11 reads harmonic amplitude
// - opcode 10 writes pair flag, or noise location when noise init set
// - select 00 command, 01/10/11 data registers A/B/C; chip select high none
// - bus driven only while read strobe and chip select are both low
// - reading the command select returns the last accepted command byte
// - address latch mode takes select from bus bits 1-0 during latch strobe
// - ready mode high when idle; interrupt mode one-cycle completion pulse
// - zero slope breakpoint copies target into current at once
module shcp_command_port #(
	parameter int ENV_COUNT = shcp_pkg::NUM_ENV
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic ale,
	input wire logic reg_sel_hi,
	input wire logic reg_sel_lo,
	input wire logic [7:0] host_bus_in,
	output logic [7:0] host_bus_out,
	output logic host_bus_oe,
	output logic int_rdy,
	input wire logic sample_tick,
	output logic [3:0] option_bits,
	output logic [1:0] control_bits,
	output logic [15:0] voice_types,
	output logic [31:0] lhp_flags,
	output logic noise_wr,
	output logic [5:0] noise_loc,
	output logic [7:0] noise_data
);

	localparam int EW = shcp_pkg::ENTRY_W;
	localparam int AW = shcp_pkg::ENV_AW;

	logic [1:0] ale_sel;
	logic [1:0] sel_now;
	logic [1:0] wr_sel;
	logic [7:0] wr_byte;
	logic wr_active;
	logic wr_prev;
	logic wr_commit;
	logic cmd_accept;
	logic [7:0] reg_a;
	logic [7:0] reg_b;
	logic [7:0] reg_c;
	logic [7:0] cmd_byte;
	logic cmd_pend;
	logic tick_pend;
	shcp_pkg::shcp_state_t state;
	logic [shcp_pkg::SUB_W-1:0] sub_cnt;
	logic [AW-1:0] swp_idx;
	logic start_cmd;
	logic start_swp;
	logic in_exec;
	logic is_wr_pitch;
	logic is_wr_vtype;
	logic is_rd_pitch;
	logic is_wr_opt;
	logic is_wr_ctl;
	logic is_wr_harm;
	logic is_pair_op;
	logic is_rd_harm;
	logic [AW-1:0] cmd_env_addr;
	logic rd_en;
	logic [AW-1:0] rd_addr;
	logic [EW-1:0] rd_data;
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [EW-1:0] wr_entry;
	logic [shcp_pkg::TGT_W-1:0] bp_tgt;
	logic [shcp_pkg::CUR_W-1:0] cur_now;

	// one update of an envelope entry for the current subsample count
	function automatic logic [EW-1:0] env_advance(
		input logic [EW-1:0] e,
		input logic [shcp_pkg::SUB_W-1:0] sub
	);
		logic [7:0] slope;
		logic [shcp_pkg::TGT_W-1:0] tgt;
		logic [shcp_pkg::CUR_W-1:0] cur;
		logic [6:0] mask;
		logic signed [19:0] step;
		logic signed [19:0] sum;
		logic signed [19:0] goal;
		logic reached;
		slope = e[shcp_pkg::SLOPE_LSB +: shcp_pkg::SLOPE_W];
		tgt = e[shcp_pkg::TGT_LSB +: shcp_pkg::TGT_W];
		cur = e[shcp_pkg::CUR_LSB +: shcp_pkg::CUR_W];
		case ({slope[shcp_pkg::RATE_EXP_HI_BIT],
			slope[shcp_pkg::RATE_EXP_LO_BIT]})
			2'h3: mask = shcp_pkg::RATE_MASK_EVERY2;
			2'h2: mask = shcp_pkg::RATE_MASK_EVERY8;
			2'h1: mask = shcp_pkg::RATE_MASK_EVERY32;
			default: mask = shcp_pkg::RATE_MASK_EVERY128;
		endcase
		// 6-bit signed step in units of 1/32 target lsb
		step = {{14{slope[shcp_pkg::SLOPE_SIGN_BIT]}},
			slope[shcp_pkg::SLOPE_SIGN_BIT], slope[shcp_pkg::MANT_W-1:0]};
		sum = $signed({2'h0, cur}) + step;
		goal = $signed({2'h0, tgt, 5'h00});
		if (slope[shcp_pkg::SLOPE_SIGN_BIT]) begin
			reached = (sum <= goal);
		end else begin
			reached = (sum >= goal);
		end
		if (slope != 8'h00 && (sub & mask) == 7'h00) begin
			if (reached) begin
				// land exactly and stop
				cur = {tgt, 5'h00};
				slope = 8'h00;
			end else begin
				cur = sum[shcp_pkg::CUR_W-1:0];
			end
		end
		return {cur, tgt, slope};
	endfunction

	// register selection and address latch
	assign sel_now = option_bits[shcp_pkg::OPT_ALE_BIT] ? ale_sel :
		{reg_sel_hi, reg_sel_lo};

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ale_sel <= 2'h0;
		end else if (ale) begin
			ale_sel <= host_bus_in[1:0];
		end
	end

	// writes complete on the trailing edge of the strobe
	assign wr_active = !cs_n && !wr_n;
	assign wr_commit = wr_prev && !wr_active;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wr_prev <= 1'b0;
			wr_sel <= 2'h0;
			wr_byte <= 8'h00;
		end else begin
			wr_prev <= wr_active;
			if (wr_active) begin
				wr_sel <= sel_now;
				wr_byte <= host_bus_in;
			end
		end
	end

	// a command arriving while another is pending is dropped
	assign cmd_accept = wr_commit && wr_sel == shcp_pkg::SEL_CMD &&
		!cmd_pend && state != shcp_pkg::ST_EXEC;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cmd_byte <= 8'h00;
			cmd_pend <= 1'b0;
		end else if (cmd_accept) begin
			cmd_byte <= wr_byte;
			cmd_pend <= 1'b1;
		end else if (start_cmd) begin
			cmd_pend <= 1'b0;
		end
	end

	// command decode
	assign is_wr_pitch = cmd_byte[7:3] == shcp_pkg::OP5_WR_PITCH;
	assign is_wr_vtype = cmd_byte[7:3] == shcp_pkg::OP5_WR_VTYPE;
	assign is_rd_pitch = cmd_byte[7:3] == shcp_pkg::OP5_RD_PITCH;
	assign is_wr_opt = cmd_byte[7:4] == shcp_pkg::OP4_WR_OPT;
	assign is_wr_ctl = cmd_byte[7:4] == shcp_pkg::OP4_WR_CTL;
	assign is_wr_harm = cmd_byte[7:6] == shcp_pkg::OP2_WR_HARM;
	assign is_pair_op = cmd_byte[7:6] == shcp_pkg::OP2_WR_PAIR;
	assign is_rd_harm = cmd_byte[7:6] == shcp_pkg::OP2_RD_HARM;
	assign cmd_env_addr = (cmd_byte[7:6] == 2'h0) ? {4'h0, cmd_byte[2:0]} :
		shcp_pkg::HARM_BASE + {1'b0, cmd_byte[5:0]};

	// sequencer
	assign start_cmd = state == shcp_pkg::ST_IDLE && cmd_pend;
	assign start_swp = state == shcp_pkg::ST_IDLE && !cmd_pend && tick_pend &&
		control_bits[shcp_pkg::CTL_RUN_BIT];
	assign in_exec = state == shcp_pkg::ST_EXEC;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state <= shcp_pkg::ST_IDLE;
		end else begin
			case (state)
				shcp_pkg::ST_IDLE: begin
					if (start_cmd) begin
						state <= shcp_pkg::ST_EXEC;
					end else if (start_swp) begin
						state <= shcp_pkg::ST_SWEEP;
					end
				end
				shcp_pkg::ST_EXEC: begin
					state <= shcp_pkg::ST_IDLE;
				end
				shcp_pkg::ST_SWEEP: begin
					if (swp_idx == shcp_pkg::ENV_LAST) begin
						state <= shcp_pkg::ST_IDLE;
					end
				end
				default: begin
					state <= shcp_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// a new tick during the clear cycle is kept
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tick_pend <= 1'b0;
		end else if (sample_tick) begin
			tick_pend <= 1'b1;
		end else if (start_swp) begin
			tick_pend <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			swp_idx <= '0;
		end else if (start_swp) begin
			swp_idx <= '0;
		end else if (state == shcp_pkg::ST_SWEEP) begin
			swp_idx <= swp_idx + 7'h01;
		end
	end

	// one sample period per completed sweep
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sub_cnt <= '0;
		end else if (state == shcp_pkg::ST_SWEEP &&
			swp_idx == shcp_pkg::ENV_LAST) begin
			sub_cnt <= sub_cnt + 7'h01;
		end
	end

	// envelope memory ports; the sweep reads one entry ahead of its write
	always_comb begin
		rd_en = 1'b0;
		rd_addr = '0;
		if (start_cmd) begin
			rd_en = 1'b1;
			rd_addr = cmd_env_addr;
		end else if (start_swp) begin
			rd_en = 1'b1;
		end else if (state == shcp_pkg::ST_SWEEP &&
			swp_idx != shcp_pkg::ENV_LAST) begin
			rd_en = 1'b1;
			rd_addr = swp_idx + 7'h01;
		end
	end

	assign cur_now = rd_data[shcp_pkg::CUR_LSB +: shcp_pkg::CUR_W];
	// harmonic targets are 8 bits, pitch targets 13
	assign bp_tgt = is_wr_pitch ? {reg_b[4:0], reg_c} : {5'h00, reg_c};

	always_comb begin
		wr_en = 1'b0;
		wr_addr = '0;
		wr_entry = '0;
		if (state == shcp_pkg::ST_SWEEP) begin
			wr_en = 1'b1;
			wr_addr = swp_idx;
			wr_entry = env_advance(rd_data, sub_cnt);
		end else if (in_exec && (is_wr_pitch || is_wr_harm)) begin
			wr_en = 1'b1;
			wr_addr = cmd_env_addr;
			if (reg_a == 8'h00) begin
				wr_entry = {bp_tgt, 5'h00, bp_tgt, reg_a};
			end else begin
				wr_entry = {cur_now, bp_tgt, reg_a};
			end
		end
	end

	shcp_env_ram #(
		.WIDTH(EW),
		.DEPTH(ENV_COUNT),
		.AW(AW)
	) u_env_ram (
		.sys_clk(sys_clk),
		.reset(reset),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_entry),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	// data registers; a read result overrides a host write in the same cycle
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			reg_a <= 8'h00;
			reg_b <= 8'h00;
			reg_c <= 8'h00;
		end else begin
			if (wr_commit && wr_sel == shcp_pkg::SEL_A) begin
				reg_a <= wr_byte;
			end
			if (in_exec && is_rd_pitch) begin
				reg_b <= {3'h0, cur_now[17:13]};
				reg_c <= cur_now[12:5];
			end else if (in_exec && is_rd_harm) begin
				reg_b <= {3'h0, cur_now[4:0]};
				reg_c <= cur_now[12:5];
			end else begin
				if (wr_commit && wr_sel == shcp_pkg::SEL_B) begin
					reg_b <= wr_byte;
				end
				if (wr_commit && wr_sel == shcp_pkg::SEL_C) begin
					reg_c <= wr_byte;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			option_bits <= shcp_pkg::OPTIONS_RST;
			control_bits <= shcp_pkg::CONTROL_RST;
		end else if (in_exec && is_wr_opt) begin
			option_bits <= cmd_byte[3:0];
		end else if (in_exec && is_wr_ctl) begin
			control_bits <= cmd_byte[1:0];
		end
	end

	// per-voice type fields and per-pair last flags
	genvar gi;
	generate
		for (gi = 0; gi < shcp_pkg::NUM_VOICES; gi++) begin : g_vtype
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					voice_types[2*gi +: 2] <= 2'h0;
				end else if (in_exec && is_wr_vtype &&
					cmd_byte[2:0] == 3'(gi)) begin
					voice_types[2*gi +: 2] <= reg_a[1:0];
				end
			end
		end
		for (gi = 0; gi < shcp_pkg::NUM_PAIRS; gi++) begin : g_pair
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					lhp_flags[gi] <= 1'b0;
				end else if (in_exec && is_pair_op &&
					!control_bits[shcp_pkg::CTL_NOISE_INIT_BIT] &&
					cmd_byte[5:1] == 5'(gi)) begin
					lhp_flags[gi] <= cmd_byte[0];
				end
			end
		end
	endgenerate

	// noise memory lives outside; the operand comes from register A
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			noise_wr <= 1'b0;
			noise_loc <= 6'h00;
			noise_data <= 8'h00;
		end else begin
			noise_wr <= in_exec && is_pair_op &&
				control_bits[shcp_pkg::CTL_NOISE_INIT_BIT];
			if (in_exec && is_pair_op) begin
				noise_loc <= cmd_byte[5:0];
				noise_data <= reg_a;
			end
		end
	end

	// host read path
	assign host_bus_oe = !cs_n && !rd_n;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			host_bus_out <= 8'h00;
		end else if (sel_now == shcp_pkg::SEL_A) begin
			host_bus_out <= reg_a;
		end else if (sel_now == shcp_pkg::SEL_B) begin
			host_bus_out <= reg_b;
		end else if (sel_now == shcp_pkg::SEL_C) begin
			host_bus_out <= reg_c;
		end else begin
			host_bus_out <= cmd_byte;
		end
	end

	// completion pin, registered so it is glitch free
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			int_rdy <= 1'b1;
		end else if (option_bits[shcp_pkg::OPT_INT_BIT]) begin
			int_rdy <= in_exec;
		end else begin
			int_rdy <= !cmd_pend && !in_exec && !cmd_accept;
		end
	end

endmodule

/* test/shcp_command_port_props.sv */
`timescale 1ns/100ps
module shcp_command_port_props #(
	parameter int ENV_COUNT = shcp_pkg::NUM_ENV
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic reg_sel_hi,
	input wire logic reg_sel_lo,
	input wire logic host_bus_oe,
	input wire logic int_rdy,
	input wire logic [3:0] option_bits,
	input wire logic [1:0] control_bits,
	input wire logic [15:0] voice_types,
	input wire logic [31:0] lhp_flags,
	input wire logic noise_wr
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	logic wr_q;
	logic [1:0] sel_q;
	logic [7:0] since;
	wire strobe = !cs_n && !wr_n;
	wire commit = wr_q && !strobe;
	// select kept from the strobe, the host may move it at release
	wire cmd_commit = commit && sel_q == 2'h0 && !option_bits[0];
	always_ff @(posedge sys_clk) begin
		wr_q <= !reset && strobe;
		if (strobe) begin
			sel_q <= {reg_sel_hi, reg_sel_lo};
		end
	end
	// worst case a command waits out a full sweep
	always_ff @(posedge sys_clk) begin
		if (reset || commit) begin
			since <= 8'h00;
		end else if (since != 8'hff) begin
			since <= since + 8'h01;
		end
	end
	a_oe_follows_strobe: assert property (
		host_bus_oe == (!cs_n && !rd_n))
		else $error("bus enable differs from read strobe");
	a_oe_off_deselect: assert property (cs_n |-> !host_bus_oe)
		else $error("bus driven without chip select");
	a_int_one_pulse: assert property (
		int_rdy && option_bits[1] && $past(option_bits[1]) |=> !int_rdy)
		else $error("completion pulse longer than one cycle");
	a_rdy_busy: assert property (
		cmd_commit && !option_bits[1] |-> ##[1:2] !int_rdy)
		else $error("ready stayed high after command");
	a_rdy_back: assert property (
		!option_bits[1] && $fell(int_rdy) |-> ##[1:200] int_rdy)
		else $error("ready never returned");
	a_noise_pulse: assert property (noise_wr |=> !noise_wr)
		else $error("noise write longer than one cycle");
	a_noise_mode: assert property (noise_wr |-> control_bits[1])
		else $error("noise write outside noise init");
	a_state_by_cmd: assert property (
		!$stable({option_bits, control_bits, voice_types, lhp_flags})
		|-> since < 8'h64)
		else $error("state changed without a command");
endmodule
bind shcp_command_port shcp_command_port_props
	#(.ENV_COUNT(ENV_COUNT)) u_props (
	.sys_clk, .reset, .cs_n, .rd_n, .wr_n, .reg_sel_hi, .reg_sel_lo,
	.host_bus_oe, .int_rdy, .option_bits, .control_bits, .voice_types,
	.lhp_flags, .noise_wr);

/* test/shcp_host_bfm.sv */
`timescale 1ns/100ps
module shcp_host_bfm (
	input wire logic sys_clk,
	input wire logic [7:0] line,
	output logic cs_n,
	output logic rd_n,
	output logic wr_n,
	output logic ale,
	output logic reg_sel_hi,
	output logic reg_sel_lo,
	output logic [7:0] bus
);
	logic alem = 1'b0;
	logic got = 1'b0;
	logic [7:0] rd_val = 8'h00;
	initial begin
		{cs_n, rd_n, wr_n, ale, reg_sel_hi, reg_sel_lo} = 6'h38;
		bus = 8'h00;
	end
	task automatic addr(input logic [1:0] s);
		if (alem) begin
			ale = 1'b1;
			bus = {6'h00, s};
			@(posedge sys_clk);
			#1;
			ale = 1'b0;
		end else begin
			{reg_sel_hi, reg_sel_lo} = s;
		end
	endtask
	task automatic wr(input logic [1:0] s, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		addr(s);
		bus = d;
		{cs_n, wr_n} = 2'h0;
		@(posedge sys_clk);
		#1;
		{cs_n, wr_n} = 2'h3;
		// released bus shows garbage, not the old byte
		bus = ~d;
	endtask
	task automatic rd(input logic [1:0] s);
		@(posedge sys_clk);
		#1;
		addr(s);
		{cs_n, rd_n} = 2'h0;
		@(posedge sys_clk);
		@(posedge sys_clk);
		rd_val = line;
		got = 1'b1;
		#1;
		{cs_n, rd_n} = 2'h3;
		got = 1'b0;
	endtask
endmodule

/* test/shcp_command_port_tb.sv */
`timescale 1ns/100ps
module shcp_command_port_tb;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic sample_tick = 1'b0;
	logic cs_n, rd_n, wr_n, ale, reg_sel_hi, reg_sel_lo, host_bus_oe;
	logic int_rdy, noise_wr;
	logic [7:0] bus, host_bus_out, noise_data;
	logic [3:0] option_bits;
	logic [1:0] control_bits;
	logic [15:0] voice_types, vt;
	logic [31:0] lhp_flags, lf;
	logic [5:0] noise_loc;
	logic [31:0] exp_q[$];
	logic [31:0] nz_q[$];
	int error_cnt = 0;
	int comparisons = 0;
	int seed = 32'h29f36459;
	wire logic [7:0] line = host_bus_oe ? host_bus_out : bus;
	shcp_command_port u_dut (.sys_clk, .reset, .cs_n, .rd_n, .wr_n, .ale,
		.reg_sel_hi, .reg_sel_lo, .host_bus_in(line), .host_bus_out,
		.host_bus_oe, .int_rdy, .sample_tick, .option_bits, .control_bits,
		.voice_types, .lhp_flags, .noise_wr, .noise_loc, .noise_data);
	shcp_host_bfm u_host (.sys_clk, .line, .cs_n, .rd_n, .wr_n, .ale,
		.reg_sel_hi, .reg_sel_lo, .bus);
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic cmd(input logic [7:0] c);
		int n;
		u_host.wr(2'h0, c);
		repeat (2) @(posedge sys_clk);
		n = 0;
		#1;
		while (int_rdy !== 1'b1 && n < 300) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n == 300) error_cnt++;
	endtask
	task automatic rdx(input logic [1:0] s, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		u_host.rd(s);
	endtask
	task automatic hbp(input logic [5:0] hi, input logic [7:0] tg,
		input logic [7:0] s);
		u_host.wr(2'h1, s);
		u_host.wr(2'h3, tg);
		cmd({2'h1, hi});
	endtask
	always @(posedge u_host.got) begin
		chk({24'h0, u_host.rd_val}, exp_q.pop_front());
	end
	always @(posedge sys_clk) begin
		if (noise_wr === 1'b1) begin
			chk({18'h0, noise_loc, noise_data}, nz_q.pop_front());
		end
	end
	initial begin
		logic [7:0] d, h;
		logic [12:0] t, cur;
		static logic [7:0] sl[6] = '{8'hff, 8'hdf, 8'hbf, 8'h9f, 8'he1,
			8'h7f};
		int u;
		repeat (8) @(posedge sys_clk);
		#1;
		reset = 1'b0;
		chk({25'h0, int_rdy, option_bits, control_bits}, 32'h40);
		chk({16'h0, voice_types}, 32'h0);
		chk(lhp_flags, 32'h0);
		for (int s = 1; s < 4; s++) begin
			d = 8'($random(seed));
			u_host.wr(2'(s), d);
			rdx(2'(s), d);
		end
		cmd(8'h2c);
		chk({28'h0, option_bits}, 32'hc);
		rdx(2'h0, 8'h2c);
		cmd(8'h3d);
		chk({30'h0, control_bits}, 32'h1);
		vt = 16'h0;
		for (int v = 0; v < 8; v++) begin
			d = 8'($random(seed));
			u_host.wr(2'h1, d);
			cmd({5'h02, 3'(v)});
			vt[2 * v +: 2] = d[1:0];
		end
		chk({16'h0, voice_types}, {16'h0, vt});
		t = 13'($random(seed));
		d = 8'($random(seed));
		u_host.wr(2'h1, 8'h00);
		u_host.wr(2'h2, {3'h0, t[12:8]});
		u_host.wr(2'h3, t[7:0]);
		cmd({5'h01, d[2:0]});
		cmd({5'h03, d[2:0]});
		rdx(2'h2, {3'h0, t[12:8]});
		rdx(2'h3, t[7:0]);
		lf = 32'h0;
		for (int i = 0; i < 3; i++) begin
			d = 8'($random(seed));
			cmd({2'h2, d[5:0]});
			lf[d[5:1]] = d[0];
		end
		cmd(8'h33);
		d = 8'($random(seed));
		h = 8'($random(seed));
		u_host.wr(2'h1, d);
		nz_q.push_back({18'h0, h[5:0], d});
		cmd({2'h2, h[5:0]});
		cmd(8'h31);
		chk(lhp_flags, lf);
		// the command that selects pulse mode gives no pulse of its own
		u_host.wr(2'h0, 8'h22);
		repeat (4) @(posedge sys_clk);
		#1;
		chk({28'h0, option_bits}, 32'h2);
		cmd(8'h31);
		cmd(8'h20);
		cmd(8'h21);
		u_host.alem = 1'b1;
		d = 8'($random(seed));
		u_host.wr(2'h2, d);
		rdx(2'h2, d);
		cmd(8'h20);
		u_host.alem = 1'b0;
		chk({28'h0, option_bits}, 32'h0);
		// targets kept mid-range so one step either way stays legal
		h = 8'h40 | (8'($random(seed)) & 8'h3f);
		for (int i = 0; i < 6; i++) begin
			hbp(6'(16 + i), h, 8'h00);
			hbp(6'(16 + i), sl[i][7] ? h - 8'h01 : h + 8'h01, sl[i]);
		end
		for (int k = 0; k < 40; k++) begin
			sample_tick = 1'b1;
			@(posedge sys_clk);
			#1;
			sample_tick = 1'b0;
			repeat (80) @(posedge sys_clk);
			#1;
		end
		for (int i = 0; i < 6; i++) begin
			u = (39 >> (7 - 2 * sl[i][6:5])) + 1;
			u = u * int'($signed({sl[i][7], sl[i][4:0]}));
			if (u > 32) u = 32;
			if (u < -32) u = -32;
			cur = {h, 5'h00} + 13'(u);
			cmd({2'h3, 6'(16 + i)});
			rdx(2'h2, {3'h0, cur[4:0]});
			rdx(2'h3, cur[12:5]);
		end
		repeat (4) @(posedge sys_clk);
		chk(32'(exp_q.size()), 32'h0);
		chk(32'(nz_q.size()), 32'h0);
		final_report();
	end
	initial begin
		#200000;
		error_cnt++;
		final_report();
	end
endmodule
